/* include/wake_event_defs.svh */
// Register indices, field positions, reset values and timing figures
`ifndef WAKE_EVENT_DEFS_SVH
`define WAKE_EVENT_DEFS_SVH
// Register indices (byte address is four times the index)
`define WT_VALUE_IDX 16'h2880
`define RST_FLAGS_IDX 16'h28B0
`define WAKE_FLAGS_IDX 16'h28B1
`define LP_CTRL_IDX 16'h28B2
`define PIN_EN_IDX 16'h28B3
`define OPT_CTRL_IDX 16'h2457
`define PIN_CFG_IDX 16'h28C0
// Low-power control bits
`define LP_SLEEP 7
`define LP_DISPLAY 6
`define LP_ARM 5
// Wake enable and wake flag bits
`define WK_TMR 5
`define WK_RX 4
`define WK_PB 3
`define WK_P4 2
`define WK_P52 1
`define WK_P55 0
// Reset-source flag bits
`define RF_CSTART 7
`define RF_RST 6
`define RF_RSTBIT 5
`define RF_OVF 4
`define RF_ERST 3
`define RF_BADVDD 2
// Flags whose setting clears each reset-source flag
`define KILL_RST 8'hB4
`define KILL_RSTBIT 8'hD4
`define KILL_ERST 8'hF0
`define KILL_OVF 8'hE4
`define KILL_CSTART 8'h74
`define KILL_BADVDD 8'h00
// Optical disable bit
`define OPT_DIS_BIT 2
// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
// Pin sample vector positions
`define PIN_PB 0
`define PIN_P4 1
`define PIN_P52 2
`define PIN_P55 3
`define PIN_RX 4
`define PIN_ORX 5
`define PIN_RSTP 6
`define PIN_ERSTP 7
`define PIN_EEN 8
`define PIN_LBAT 9
`define PIN_N 10
// Timing
`define CLK_NS 10
`define SLOW_HZ 32768
`define SLOW_CYCLES (1000000000 / (`SLOW_HZ * `CLK_NS))
`define SAMPLE_MS 2
`define STABLE_MS 64
`define STABLE_SAMPLES (`STABLE_MS / `SAMPLE_MS)
`define SAMPLE_CYCLES (`SAMPLE_MS * 1000000 / `CLK_NS)
`endif

/* include/wake_event_pkg.sv */
// Types shared by the wake logic modules
`include "wake_event_defs.svh"
package wake_event_pkg;
   // Run or low-power mode, one-hot
   typedef enum logic [1:0]
   {
      MODE_RUN = 2'b01,
      MODE_LOW = 2'b10
   } mode_e;
   // Wake timer state
   typedef struct packed
   {
      logic [7:0] count;
      logic [15:0] secCnt;
      logic armed;
      logic running;
      logic expire;
   } timer_s;
   // Debounce state
   typedef struct packed
   {
      logic [7:0] count;
      logic high;
   } deb_s;
   // Main block state
   typedef struct packed
   {
      mode_e mode;
      logic [`PIN_N-1:0] sync1;
      logic [`PIN_N-1:0] sync2;
      logic [`PIN_N-1:0] prev;
      logic [7:0] timerValue;
      logic [4:0] pinEnable;
      logic [2:0] pinConfig;
      logic optDisable;
      logic sleepBit;
      logic displayBit;
      logic armLoad;
      logic wake;
      logic [7:0] resetFlags;
      logic [5:0] wakeFlags;
      logic ack;
      logic [31:0] rdata;
      logic [11:0] slowCnt;
      logic [17:0] sampleCnt;
      logic slowTick;
      logic sampleTick;
   } main_s;
endpackage

/* rtl/wake_debounce.sv */
// High-level debounce filter for one wake pin
`timescale 1ns/1ns
`default_nettype none
`include "wake_event_defs.svh"
module wake_debounce
   import wake_event_pkg::*;
#(
   parameter int SAMPLES = `STABLE_SAMPLES
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Sampling
   input wire logic sampleTick,
   input wire logic pinLevel,
   output logic stableHigh
);
   initial
   begin
      if (SAMPLES < 1 || SAMPLES > 255)
         $error("SAMPLES out of range");
   end
   localparam logic [7:0] LAST = 8'(SAMPLES);
   deb_s st;
   deb_s next_st;
   // Count consecutive high samples, any low sample restarts
   always_comb
   begin
      next_st = st;
      if (sampleTick)
      begin
         if (!pinLevel)
         begin
            next_st.count = `RST_BYTE;
            next_st.high = 1'b0;
         end
         else if (st.count != LAST)
            next_st.count = st.count + 8'h01;
         else
            next_st.high = 1'b1;
      end
   end
   // State register
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end
   assign stableHigh = st.high;
endmodule
`default_nettype wire

/* rtl/wake_timer.sv */
// Seconds wake timer, counts from the slow clock tick
`timescale 1ns/1ns
`default_nettype none
`include "wake_event_defs.svh"
module wake_timer
   import wake_event_pkg::*;
#(
   parameter int SEC_TICKS = `SLOW_HZ
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic slowTick,
   input wire logic armLoad,
   input wire logic [7:0] loadValue,
   input wire logic lowPower,
   // Status
   output logic armed,
   output logic expire
);
   initial
   begin
      if (SEC_TICKS < 2 || SEC_TICKS > 65535)
         $error("SEC_TICKS out of range");
   end
   localparam logic [15:0] SEC_LAST = 16'(SEC_TICKS - 1);
   timer_s st;
   timer_s next_st;
   // Arm, start on low-power entry, count seconds
   always_comb
   begin
      next_st = st;
      next_st.expire = 1'b0;
      if (armLoad)
      begin
         next_st.count = loadValue;
         next_st.armed = 1'b1;
         next_st.running = 1'b0;
      end
      else if (!lowPower)
         next_st.running = 1'b0;
      else if (st.armed && !st.running)
      begin
         next_st.running = 1'b1;
         next_st.secCnt = 16'h0000;
      end
      else if (st.running && slowTick)
      begin
         if (st.secCnt != SEC_LAST)
            next_st.secCnt = st.secCnt + 16'h0001;
         else
         begin
            next_st.secCnt = 16'h0000;
            // Zero counts one more second, so value plus one
            if (st.count == 8'h00)
            begin
               next_st.expire = 1'b1;
               next_st.armed = 1'b0;
               next_st.running = 1'b0;
            end
            else
               next_st.count = st.count - 8'h01;
         end
      end
   end
   // State register
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end
   assign armed = st.armed;
   assign expire = st.expire;
   // Checks
   a_no_early_count: assert property (@(posedge mclk) disable iff (!rst_n)
      !lowPower && !armLoad |=> !st.running)
      else $error("timer runs outside low power");
endmodule
`default_nettype wire

/* rtl/wake_event_logic.sv */
// Wake and reset-source logic with its register file
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "wake_event_defs.svh"
module wake_event_logic
   import wake_event_pkg::*;
#(
   parameter int SEC_TICKS = `SLOW_HZ,
   parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
   parameter int STABLE_SAMPLES = `STABLE_SAMPLES
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [17:2] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Wake pins
   input wire logic pushbuttonPin,
   input wire logic digitalPinFour,
   input wire logic digitalPin52,
   input wire logic digitalPinFiftyFive,
   input wire logic serialRxPin,
   input wire logic opticalReceivePin,
   // Reset sources
   input wire logic resetPin,
   input wire logic emulatorResetPin,
   input wire logic emulatorEnablePin,
   input wire logic lowBatteryPin,
   input wire logic softResetEvent,
   input wire logic watchdogEvent,
   input wire logic coldStartEvent,
   // Processor and mode outputs
   output logic wakeActive,
   output logic mpuHoldReset,
   output logic sleepState,
   output logic displayOnlyRequest
);
   initial
   begin
      if (SAMPLE_CYCLES < 2 || SAMPLE_CYCLES > 262143)
         $error("SAMPLE_CYCLES out of range");
   end
   localparam logic [17:0] SAMPLE_LAST = 18'(SAMPLE_CYCLES - 1);
   localparam logic [11:0] SLOW_LAST = 12'(`SLOW_CYCLES - 1);

   main_s st; // All registered state
   main_s next_st; // Next state
   logic debPb; // Debounced pushbutton
   logic debP52; // Debounced pin 52
   logic debP55; // Debounced pin 55
   logic timerArmed; // Timer armed status
   logic timerExpire; // Timer expiry pulse
   logic [`PIN_N-1:0] rise; // Rising edges of synced pins
   logic [`PIN_N-1:0] fall; // Falling edges of synced pins
   logic [5:0] wakeEv; // Wake events per flag bit
   logic [5:0] flagHold; // Flags held cleared
   logic [7:0] rstSet; // Reset-source set events
   logic enterLow; // Sleep or display entry write
   logic access; // Bus access this cycle
   logic [31:0] rdMux; // Read data mux

   // Register index match
   function automatic logic hit(input logic [17:2] a, input logic [15:0] idx);
      hit = (a == idx);
   endfunction

   // Reset-source flag update with kill matrix
   function automatic logic nextRf(input logic cur, input logic set,
                                   input logic [7:0] sets, input logic [7:0] kill);
      nextRf = set | (cur & ~|(sets & kill));
   endfunction

   // Debounce filters for the level-sensitive pins
   wake_debounce #(.SAMPLES(STABLE_SAMPLES)) u_deb_pb
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .sampleTick(st.sampleTick),
      .pinLevel(st.sync2[`PIN_PB]),
      .stableHigh(debPb)
   );
   wake_debounce #(.SAMPLES(STABLE_SAMPLES)) u_deb_p52
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .sampleTick(st.sampleTick),
      .pinLevel(st.sync2[`PIN_P52]),
      .stableHigh(debP52)
   );
   wake_debounce #(.SAMPLES(STABLE_SAMPLES)) u_deb_p55
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .sampleTick(st.sampleTick),
      .pinLevel(st.sync2[`PIN_P55]),
      .stableHigh(debP55)
   );

   // Seconds wake timer
   wake_timer #(.SEC_TICKS(SEC_TICKS)) u_timer
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .slowTick(st.slowTick),
      .armLoad(st.armLoad),
      .loadValue(st.timerValue),
      .lowPower(st.mode == MODE_LOW),
      .armed(timerArmed),
      .expire(timerExpire)
   );

   // Edge detection on synchronised pins
   assign rise = st.sync2 & ~st.prev;
   assign fall = ~st.sync2 & st.prev;

   // Wake events and flag hold conditions
   always_comb
   begin
      wakeEv = 6'h00;
      flagHold = 6'h00;
      wakeEv[`WK_TMR] = timerExpire;
      wakeEv[`WK_PB] = st.pinEnable[`WK_PB] & debPb;
      // Either edge taken on the serial line
      wakeEv[`WK_RX] = st.pinEnable[`WK_RX] & (rise[`PIN_RX] | fall[`PIN_RX]);
      wakeEv[`WK_P4] = st.pinEnable[`WK_P4] & st.pinConfig[`WK_P4] & rise[`PIN_P4];
      wakeEv[`WK_P52] = st.pinEnable[`WK_P52] & st.pinConfig[`WK_P52] & debP52;
      if (st.optDisable)
      begin
         wakeEv[`WK_P55] = st.pinEnable[`WK_P55] & st.pinConfig[`WK_P55] & debP55;
         flagHold[`WK_P55] = ~(st.pinEnable[`WK_P55] & st.pinConfig[`WK_P55]);
      end
      else
      begin
         wakeEv[`WK_P55] = st.pinEnable[`WK_P55] & (rise[`PIN_ORX] | fall[`PIN_ORX]);
         flagHold[`WK_P55] = ~st.pinEnable[`WK_P55];
      end
      flagHold[`WK_P4] = ~(st.pinEnable[`WK_P4] & st.pinConfig[`WK_P4]);
      flagHold[`WK_P52] = ~(st.pinEnable[`WK_P52] & st.pinConfig[`WK_P52]);
   end

   // Reset-source events
   always_comb
   begin
      rstSet = 8'h00;
      rstSet[`RF_CSTART] = coldStartEvent;
      rstSet[`RF_RST] = rise[`PIN_RSTP];
      rstSet[`RF_RSTBIT] = softResetEvent;
      rstSet[`RF_OVF] = watchdogEvent;
      rstSet[`RF_ERST] = rise[`PIN_ERSTP] & st.sync2[`PIN_EEN];
      rstSet[`RF_BADVDD] = rise[`PIN_LBAT];
   end

   assign access = cyc_i & stb_i & ~st.ack;
   assign enterLow = access & we_i & sel_i[0] & hit(adr_i, `LP_CTRL_IDX)
                   & (dat_i[`LP_SLEEP] | dat_i[`LP_DISPLAY]);

   // Register read mux, unmapped reads as zero
   always_comb
   begin
      rdMux = `RST_WORD;
      if (hit(adr_i, `WT_VALUE_IDX))
         rdMux[7:0] = st.timerValue;
      else if (hit(adr_i, `RST_FLAGS_IDX))
         rdMux[7:0] = st.resetFlags;
      else if (hit(adr_i, `WAKE_FLAGS_IDX))
         rdMux[5:0] = st.wakeFlags;
      else if (hit(adr_i, `LP_CTRL_IDX))
         rdMux[7:5] = {st.sleepBit, st.displayBit, timerArmed};
      else if (hit(adr_i, `PIN_EN_IDX))
         rdMux[4:0] = st.pinEnable;
      else if (hit(adr_i, `OPT_CTRL_IDX))
         rdMux[`OPT_DIS_BIT] = st.optDisable;
      else if (hit(adr_i, `PIN_CFG_IDX))
         rdMux[2:0] = st.pinConfig;
   end

   // Next-state logic
   always_comb
   begin
      next_st = st;
      // Pin synchronisers and edge history
      next_st.sync1 = {lowBatteryPin, emulatorEnablePin, emulatorResetPin, resetPin,
                       opticalReceivePin, serialRxPin, digitalPinFiftyFive,
                       digitalPin52, digitalPinFour, pushbuttonPin};
      next_st.sync2 = st.sync1;
      next_st.prev = st.sync2;
      // Slow clock and debounce sample dividers
      next_st.slowTick = (st.slowCnt == SLOW_LAST);
      next_st.slowCnt = next_st.slowTick ? 12'h000 : st.slowCnt + 12'h001;
      next_st.sampleTick = (st.sampleCnt == SAMPLE_LAST);
      next_st.sampleCnt = next_st.sampleTick ? 18'h00000 : st.sampleCnt + 18'h00001;
      next_st.armLoad = 1'b0;
      next_st.ack = access;
      next_st.rdata = access ? rdMux : st.rdata;
      // Register writes
      if (access && we_i && sel_i[0])
      begin
         if (hit(adr_i, `WT_VALUE_IDX))
            next_st.timerValue = dat_i[7:0];
         else if (hit(adr_i, `LP_CTRL_IDX))
         begin
            next_st.armLoad = dat_i[`LP_ARM];
            next_st.sleepBit = dat_i[`LP_SLEEP];
            next_st.displayBit = dat_i[`LP_DISPLAY];
         end
         else if (hit(adr_i, `PIN_EN_IDX))
            next_st.pinEnable = dat_i[4:0];
         else if (hit(adr_i, `OPT_CTRL_IDX))
            next_st.optDisable = dat_i[`OPT_DIS_BIT];
         else if (hit(adr_i, `PIN_CFG_IDX))
            next_st.pinConfig = dat_i[2:0];
      end
      // Mode sequencing
      case (st.mode)
         MODE_RUN:
         begin
            if (enterLow)
            begin
               next_st.mode = MODE_LOW;
               next_st.wake = 1'b0;
            end
         end
         MODE_LOW:
         begin
            // Stay in low power until a wake or reset event
            if (|wakeEv || |rstSet)
            begin
               next_st.mode = MODE_RUN;
               next_st.wake = 1'b1;
               next_st.sleepBit = 1'b0;
               next_st.displayBit = 1'b0;
            end
         end
         default:
         begin
            next_st.mode = MODE_RUN;
            next_st.wake = 1'b1;
         end
      endcase
      // A reset source always restarts the processor
      if (|rstSet)
      begin
         next_st.mode = MODE_RUN;
         next_st.wake = 1'b1;
      end
      // Wake flags: set beats clear, held flags forced low
      next_st.wakeFlags = ((enterLow ? 6'h00 : st.wakeFlags) | wakeEv) & ~flagHold;
      // Reset flags: cleared by a sleep or display entry write or, except the bad-VDD flag, by other flags setting
      next_st.resetFlags = enterLow ? `RST_BYTE : st.resetFlags;
      next_st.resetFlags[`RF_RST] = nextRf(next_st.resetFlags[`RF_RST],
         rstSet[`RF_RST], rstSet, `KILL_RST);
      next_st.resetFlags[`RF_RSTBIT] = nextRf(next_st.resetFlags[`RF_RSTBIT],
         rstSet[`RF_RSTBIT], rstSet, `KILL_RSTBIT);
      next_st.resetFlags[`RF_ERST] = nextRf(next_st.resetFlags[`RF_ERST],
         rstSet[`RF_ERST], rstSet, `KILL_ERST);
      next_st.resetFlags[`RF_OVF] = nextRf(next_st.resetFlags[`RF_OVF],
         rstSet[`RF_OVF], rstSet, `KILL_OVF);
      next_st.resetFlags[`RF_CSTART] = nextRf(next_st.resetFlags[`RF_CSTART],
         rstSet[`RF_CSTART], rstSet, `KILL_CSTART);
      next_st.resetFlags[`RF_BADVDD] = nextRf(next_st.resetFlags[`RF_BADVDD],
         rstSet[`RF_BADVDD], rstSet, `KILL_BADVDD);
   end

   // State register, processor starts awake
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         st <= '0;
         st.mode <= MODE_RUN;
         st.wake <= 1'b1;
      end
      else
         st <= next_st;
   end

   // Outputs
   assign dat_o = st.rdata;
   assign ack_o = st.ack;
   assign wakeActive = st.wake;
   assign mpuHoldReset = ~st.wake;
   assign sleepState = st.sleepBit;
   assign displayOnlyRequest = st.displayBit;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_wake_drop: assert property (enterLow && st.mode == MODE_RUN && !(|rstSet)
      |=> !wakeActive && st.wakeFlags[`WK_PB] == $past(wakeEv[`WK_PB]))
      else $error("wake did not fall on low-power entry");
   a_hold_reset: assert property (st.mode == MODE_LOW |-> mpuHoldReset)
      else $error("processor released in low power");
   a_timer_wake: assert property (st.mode == MODE_LOW && timerExpire
      |=> wakeActive && st.wakeFlags[`WK_TMR] && !mpuHoldReset)
      else $error("timer expiry did not wake");
   a_pb_wake: assert property (st.mode == MODE_LOW && st.pinEnable[`WK_PB] && debPb
      |=> wakeActive ##1 wakeActive)
      else $error("pushbutton did not wake");
   a_p4_hold: assert property (!(st.pinEnable[`WK_P4] && st.pinConfig[`WK_P4])
      |=> !st.wakeFlags[`WK_P4])
      else $error("pin four flag not held clear");
   a_p52_hold: assert property (!(st.pinEnable[`WK_P52] && st.pinConfig[`WK_P52])
      |=> !st.wakeFlags[`WK_P52])
      else $error("pin 52 flag not held clear");
   a_rst_kill: assert property (rstSet[`RF_CSTART] && !rstSet[`RF_RST]
      |=> !st.resetFlags[`RF_RST] && st.resetFlags[`RF_CSTART])
      else $error("cold start did not clear pin reset flag");
   a_ovf_kill: assert property (rstSet[`RF_RSTBIT] && !rstSet[`RF_OVF]
      |=> !st.resetFlags[`RF_OVF])
      else $error("soft reset did not clear watchdog flag");
   a_emu_gate: assert property ($rose(st.resetFlags[`RF_ERST])
      |-> $past(st.sync2[`PIN_EEN]))
      else $error("emulator reset flagged while disabled");
   a_ack_once: assert property (ack_o |=> !ack_o)
      else $error("ack held two cycles");
endmodule
`default_nettype wire

/* bench/wake_pin_model.sv */
// Far-side wake pin driver with a minimum high time
`timescale 1ns/1ns
`default_nettype none
module wake_pin_model
#(
   parameter int HOLD = 200
)
(
   // Clock
   input wire logic mclk,
   // Requested levels
   input wire logic [5:0] want,
   // Driven pin levels
   output logic [5:0] pins
);
   logic [5:0] lvl = 6'h00; // Present pin levels
   logic [7:0] hold [6] = '{default: 8'h00}; // Cycles left high
   assign pins = lvl;
   // A pin that rises stays high at least HOLD cycles
   always @(posedge mclk)
   begin
      for (int i = 0; i < 6; i++)
      begin
         if (hold[i] != 8'h00)
            hold[i] <= hold[i] - 8'h01;
         else
            lvl[i] <= want[i];
         if (want[i] && !lvl[i] && hold[i] == 8'h00)
            hold[i] <= HOLD[7:0];
      end
   end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the wake and reset-source logic
`timescale 1ns/1ns
`default_nettype none
`include "wake_event_defs.svh"
module tb
   import wake_event_pkg::*;
;
   // Clock, reset and bus
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [15:0] adr = 16'h0000;
   logic [3:0] sel = 4'h1;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack;
   logic [7:0] rd;
   // Pins and events
   logic [5:0] want = 6'h00;
   logic [5:0] pins;
   logic [2:0] evt = 3'h0;
   logic [3:0] rsp = 4'h0; // Reset, emulator reset, emulator enable, low battery pins
   logic wakeActive, mpuHoldReset, sleepState, displayOnly;
   int error_cnt = 0;
   int check_count = 0;
   localparam int SLOW = 3051; // Clocks per slow tick
   // Design with shortened counts
   wake_event_logic #(.SEC_TICKS(4), .SAMPLE_CYCLES(8), .STABLE_SAMPLES(2)) dut_u (
      .mclk(mclk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .pushbuttonPin(pins[0]), .digitalPinFour(pins[1]), .digitalPin52(pins[2]),
      .digitalPinFiftyFive(pins[3]), .serialRxPin(pins[4]),
      .opticalReceivePin(pins[5]), .resetPin(rsp[0]), .emulatorResetPin(rsp[1]),
      .emulatorEnablePin(rsp[2]), .lowBatteryPin(rsp[3]), .coldStartEvent(evt[0]),
      .softResetEvent(evt[1]), .watchdogEvent(evt[2]), .wakeActive(wakeActive),
      .mpuHoldReset(mpuHoldReset), .sleepState(sleepState),
      .displayOnlyRequest(displayOnly));
   // Far-side pin drivers
   wake_pin_model pin_u (.mclk(mclk), .want(want), .pins(pins));
   // Clock generator
   initial
   begin
      forever #5 mclk = ~mclk;
   end
   // Compare and count
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One classic Wishbone cycle, read byte lands in rd
   task wb(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      @(posedge mclk);
      while (ack !== 1'b1)
         @(posedge mclk);
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Bounded wait for wake
   task wait_wake(input int lim);
      int n;
      n = 0;
      while (wakeActive !== 1'b1 && n < lim)
      begin
         @(posedge mclk);
         n++;
      end
   endtask
   // One-cycle reset-source event
   task pulse(input int i);
      @(posedge mclk);
      evt[i] <= 1'b1;
      @(posedge mclk);
      evt[i] <= 1'b0;
   endtask
   // Reset-source pin raised for four cycles, flag settled on return
   task pin_evt(input int i);
      @(posedge mclk);
      rsp[i] <= 1'b1;
      repeat (4) @(posedge mclk);
      rsp[i] <= 1'b0;
   endtask
   // Reset values, read-back, unmapped index
   task test_regs;
      wb(1'b0, `PIN_EN_IDX, 8'h00);
      check("enables", rd, 8'h00);
      wb(1'b0, `LP_CTRL_IDX, 8'h00);
      check("lp ctrl", rd, 8'h00);
      wb(1'b1, `WT_VALUE_IDX, 8'hA5);
      wb(1'b0, `WT_VALUE_IDX, 8'h00);
      check("timer value", rd, 8'hA5);
      wb(1'b0, 16'h1000, 8'h00);
      check("unmapped", rd, 8'h00);
      check("hold run", {7'h00, mpuHoldReset}, 8'h00);
      $display("test regs done");
   endtask
   // Pin four rising edge wakes from sleep
   task test_pin4;
      wb(1'b1, `PIN_CFG_IDX, 8'h07);
      wb(1'b1, `PIN_EN_IDX, 8'h14);
      wb(1'b1, `LP_CTRL_IDX, 8'h80);
      repeat (2) @(posedge mclk);
      check("wake low", {7'h00, wakeActive}, 8'h00);
      check("hold", {7'h00, mpuHoldReset}, 8'h01);
      check("sleep", {7'h00, sleepState}, 8'h01);
      wb(1'b0, `WAKE_FLAGS_IDX, 8'h00);
      check("flags clear", rd, 8'h00);
      @(posedge mclk);
      want <= 6'h12;
      wait_wake(300);
      check("pin4 wake", {7'h00, wakeActive}, 8'h01);
      wb(1'b0, `WAKE_FLAGS_IDX, 8'h00);
      check("pin4 rx flags", rd, 8'h14);
      want <= 6'h00;
      $display("test pin4 done");
   endtask
   // Armed timer starts only at sleep entry
   task test_timer;
      wb(1'b1, `WT_VALUE_IDX, 8'h00);
      wb(1'b1, `LP_CTRL_IDX, 8'h20);
      repeat (5 * SLOW) @(posedge mclk);
      wb(1'b1, `LP_CTRL_IDX, 8'h80);
      repeat (3 * SLOW - 20) @(posedge mclk);
      check("timer early", {7'h00, wakeActive}, 8'h00);
      wait_wake(2 * SLOW + 40);
      check("timer wake", {7'h00, wakeActive}, 8'h01);
      wb(1'b0, `WAKE_FLAGS_IDX, 8'h00);
      check("timer flag", rd, 8'h20);
      $display("test timer done");
   endtask
   // Reset-source flags and their clear matrix
   task test_resets;
      pulse(0);
      wb(1'b0, `RST_FLAGS_IDX, 8'h00);
      check("cold flag", rd, 8'h80);
      pulse(1);
      wb(1'b0, `RST_FLAGS_IDX, 8'h00);
      check("soft kills cold", rd, 8'h20);
      pulse(2);
      wb(1'b0, `RST_FLAGS_IDX, 8'h00);
      check("wdog kills soft", rd, 8'h10);
      pin_evt(1);
      wb(1'b0, `RST_FLAGS_IDX, 8'h00);
      check("emu disabled", rd, 8'h10);
      @(posedge mclk);
      rsp[2] <= 1'b1;
      pin_evt(1);
      wb(1'b0, `RST_FLAGS_IDX, 8'h00);
      check("emu enabled", rd, 8'h18);
      pin_evt(0);
      wb(1'b0, `RST_FLAGS_IDX, 8'h00);
      check("pin kills others", rd, 8'h40);
      pin_evt(3);
      wb(1'b0, `RST_FLAGS_IDX, 8'h00);
      check("lowbat kills pin", rd, 8'h04);
      $display("test resets done");
   endtask
   // Disabled pushbutton ignored, optical edge wakes
   task test_optical;
      wb(1'b1, `PIN_EN_IDX, 8'h01);
      wb(1'b1, `LP_CTRL_IDX, 8'h40);
      @(posedge mclk);
      want <= 6'h01;
      repeat (100) @(posedge mclk);
      check("pb disabled", {7'h00, wakeActive}, 8'h00);
      check("display", {7'h00, displayOnly}, 8'h01);
      want <= 6'h21;
      wait_wake(300);
      check("optical wake", {7'h00, wakeActive}, 8'h01);
      check("display cleared", {7'h00, displayOnly}, 8'h00);
      wb(1'b0, `WAKE_FLAGS_IDX, 8'h00);
      check("optical flag", rd, 8'h01);
      want <= 6'h00;
      $display("test optical done");
   endtask
   // Debounced level pins wake with optical disable set
   task test_level;
      wb(1'b1, `OPT_CTRL_IDX, 8'h04);
      repeat (250) @(posedge mclk);
      wb(1'b1, `PIN_EN_IDX, 8'h0B);
      wb(1'b1, `LP_CTRL_IDX, 8'h80);
      @(posedge mclk);
      want <= 6'h0D;
      wait_wake(300);
      check("level wake", {7'h00, wakeActive}, 8'h01);
      check("sleep cleared", {7'h00, sleepState}, 8'h00);
      wb(1'b0, `WAKE_FLAGS_IDX, 8'h00);
      check("level flags", rd, 8'h0B);
      want <= 6'h00;
      $display("test level done");
   endtask
   // Counts, verdict and end of run
   task test_done;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      repeat (90000) @(posedge mclk);
      error_cnt++;
      test_done;
   end
   // Main sequence
   initial
   begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      test_regs;
      test_pin4;
      test_timer;
      test_resets;
      test_optical;
      test_level;
      test_done;
   end
endmodule
`default_nettype wire
